// File: cell_pkg.sv
// Package with constants, layouts and types for the adaptive logic cell
package cell_pkg;

  // Register byte offsets
  localparam logic [7:0] MODE_OFS      = 8'h00;
  localparam logic [7:0] LUT_TOP_LO    = 8'h04;
  localparam logic [7:0] LUT_TOP_HI    = 8'h08;
  localparam logic [7:0] LUT_BOT_LO    = 8'h0c;
  localparam logic [7:0] LUT_BOT_HI    = 8'h10;
  localparam logic [7:0] FLOP_TOP_OFS  = 8'h14;
  localparam logic [7:0] FLOP_BOT_OFS  = 8'h18;
  localparam logic [7:0] OUT_CFG_OFS   = 8'h1c;
  localparam logic [7:0] STATUS_OFS    = 8'h20;

  // Flop configuration field positions
  localparam int FC_SRC_LSB   = 0;
  localparam int FC_PACK_LSB  = 2;
  localparam int FC_GATE_LSB  = 4;
  localparam int FC_ACLR_BIT  = 6;
  localparam int FC_SCLR_BIT  = 7;
  localparam int FC_SLOAD_BIT = 8;
  localparam int FC_FB_BIT    = 9;
  localparam int FC_WIDTH     = 10;

  // Reset values
  localparam logic [2:0]  MODE_RST     = 3'h0;
  localparam logic [63:0] LUT_RST      = 64'h0;
  localparam logic [9:0]  FLOP_CFG_RST = 10'h000;
  localparam logic [3:0]  OUT_CFG_RST  = 4'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {MODE_NORMAL, MODE_EXTENDED, MODE_ARITH, MODE_SHARED, MODE_LUTREG} mode_t;
  typedef enum logic [1:0] {SRC_LUT, SRC_PACK, SRC_CHAIN, SRC_HOLD} flop_src_t;
  typedef enum logic [1:0] {PACK_LOWER_E, PACK_LOWER_F, PACK_UPPER_F, PACK_UPPER_E} pack_lane_t;

endpackage

// File: adaptive_logic_cell.sv
// Adaptive logic cell: two LUT halves, two flops, output drivers, AXI4-Lite config
`timescale 1ns/100ps
module adaptive_logic_cell
(
  input  wire logic        i_clk_sys,            // System clock, 40 MHz
  input  wire logic        i_rst_n,              // Async reset, active low
  input  wire logic        i_fabric_run,         // High while cluster clocks run
  input  wire logic        i_data_a,             // Shared input a
  input  wire logic        i_data_b,             // Shared input b
  input  wire logic        i_data_c,             // Shared input c
  input  wire logic        i_data_d,             // Shared input d
  input  wire logic        i_lower_sel_e,        // Lower half e input
  input  wire logic        i_lower_sel_f,        // Lower half f input
  input  wire logic        i_upper_sel_e,        // Upper half e input
  input  wire logic        i_upper_sel_f,        // Upper half f input
  input  wire logic        i_carry_in,           // Carry chain in
  input  wire logic        i_share_in,           // Shared arithmetic chain in
  input  wire logic        i_chain_in,           // Register chain in
  input  wire logic [2:0]  i_cluster_clock_gate, // Cluster clock enables a..c
  input  wire logic [1:0]  i_cluster_async_clear,// Cluster async clears a, b
  input  wire logic        i_sync_clear,         // Cluster sync clear
  input  wire logic        i_sync_load,          // Cluster sync load
  input  wire logic [1:0]  i_sync_data,          // Alternate load data, top/bottom
  output logic             o_top_route0,         // Top set routed output 0 / local
  output logic             o_top_route1,         // Top set routed output 1
  output logic             o_top_local,          // Top set local output
  output logic             o_bot_route0,         // Bottom set routed output 0 / local
  output logic             o_bot_route1,         // Bottom set routed output 1
  output logic             o_bot_local,          // Bottom set local output
  output logic             o_chain_out,          // Register chain out
  output logic             o_carry_out,          // Carry chain out
  output logic             o_share_out,          // Shared chain out
  input  wire logic [7:0]  i_s_axi_awaddr,       // Write address
  input  wire logic        i_s_axi_awvalid,      // Write address valid
  output logic             o_s_axi_awready,      // Write address ready
  input  wire logic [31:0] i_s_axi_wdata,        // Write data
  input  wire logic [3:0]  i_s_axi_wstrb,        // Write strobes
  input  wire logic        i_s_axi_wvalid,       // Write data valid
  output logic             o_s_axi_wready,       // Write data ready
  output logic [1:0]       o_s_axi_bresp,        // Write response
  output logic             o_s_axi_bvalid,       // Write response valid
  input  wire logic        i_s_axi_bready,       // Write response ready
  input  wire logic [7:0]  i_s_axi_araddr,       // Read address
  input  wire logic        i_s_axi_arvalid,      // Read address valid
  output logic             o_s_axi_arready,      // Read address ready
  output logic [31:0]      o_s_axi_rdata,        // Read data
  output logic [1:0]       o_s_axi_rresp,        // Read response
  output logic             o_s_axi_rvalid,       // Read data valid
  input  wire logic        i_s_axi_rready        // Read data ready
);
  import cell_pkg::*;

  // Reset synchroniser; only the second stage is used
  logic rst_meta_n;
  logic rst_sync_n;
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Configuration state
  mode_t                mode, next_mode;
  logic [63:0]          lut_top, next_lut_top;
  logic [63:0]          lut_bot, next_lut_bot;
  logic [FC_WIDTH-1:0]  flop_cfg [2];
  logic [FC_WIDTH-1:0]  next_flop_cfg [2];
  logic [3:0]           out_cfg, next_out_cfg;
  // Bus state
  logic                 aw_held, next_aw_held;
  logic                 w_held, next_w_held;
  logic [7:0]           aw_addr, next_aw_addr;
  logic [31:0]          w_data, next_w_data;
  logic [3:0]           w_strb, next_w_strb;
  logic                 bvalid, next_bvalid;
  logic [1:0]           bresp, next_bresp;
  logic                 rvalid, next_rvalid;
  logic [1:0]           rresp, next_rresp;
  logic [31:0]          rdata, next_rdata;
  logic [31:0]          status;

  // Bytes of a word merged under the strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[b*8 +: 8] = nw[b*8 +: 8];
    end
    return res;
  endfunction

  assign o_s_axi_awready = !aw_held && !bvalid;
  assign o_s_axi_wready  = !w_held && !bvalid;
  assign o_s_axi_bvalid  = bvalid;
  assign o_s_axi_bresp   = bresp;
  assign o_s_axi_arready = !rvalid;
  assign o_s_axi_rvalid  = rvalid;
  assign o_s_axi_rresp   = rresp;
  assign o_s_axi_rdata   = rdata;

  // Write path: address and data taken in either order, then one response.
  // Writes are refused with SLVERR while the fabric runs, so the cell never
  // sees its function change under a live clock.
  always_comb
  begin
    logic [31:0] cur;
    cur           = 32'h0;
    next_aw_held  = aw_held;
    next_w_held   = w_held;
    next_aw_addr  = aw_addr;
    next_w_data   = w_data;
    next_w_strb   = w_strb;
    next_bvalid   = bvalid;
    next_bresp    = bresp;
    next_mode     = mode;
    next_lut_top  = lut_top;
    next_lut_bot  = lut_bot;
    next_flop_cfg = flop_cfg;
    next_out_cfg  = out_cfg;
    if (i_s_axi_awvalid && o_s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = i_s_axi_wdata;
      next_w_strb = i_s_axi_wstrb;
    end
    if (bvalid && i_s_axi_bready)
      next_bvalid = 1'b0;
    if (aw_held && w_held)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      if (i_fabric_run)
        next_bresp = RESP_SLVERR;
      else
      begin
        unique case (aw_addr)
          MODE_OFS:
          begin
            cur       = merge({29'h0, mode}, w_data, w_strb);
            next_mode = mode_t'(cur[2:0]);
          end
          LUT_TOP_LO: next_lut_top[31:0]  = merge(lut_top[31:0], w_data, w_strb);
          LUT_TOP_HI: next_lut_top[63:32] = merge(lut_top[63:32], w_data, w_strb);
          LUT_BOT_LO: next_lut_bot[31:0]  = merge(lut_bot[31:0], w_data, w_strb);
          LUT_BOT_HI: next_lut_bot[63:32] = merge(lut_bot[63:32], w_data, w_strb);
          FLOP_TOP_OFS:
          begin
            cur              = merge({22'h0, flop_cfg[0]}, w_data, w_strb);
            next_flop_cfg[0] = cur[FC_WIDTH-1:0];
          end
          FLOP_BOT_OFS:
          begin
            cur              = merge({22'h0, flop_cfg[1]}, w_data, w_strb);
            next_flop_cfg[1] = cur[FC_WIDTH-1:0];
          end
          OUT_CFG_OFS:
          begin
            cur          = merge({28'h0, out_cfg}, w_data, w_strb);
            next_out_cfg = cur[3:0];
          end
          STATUS_OFS: next_bresp = RESP_SLVERR; // Read-only
          default:    next_bresp = RESP_DECERR;
        endcase
      end
    end
  end

  // Write path registers
  always_ff @(posedge i_clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      aw_addr  <= 8'h00;
      w_data   <= 32'h0;
      w_strb   <= 4'h0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
      mode     <= mode_t'(MODE_RST);
      lut_top  <= LUT_RST;
      lut_bot  <= LUT_RST;
      flop_cfg <= '{FLOP_CFG_RST, FLOP_CFG_RST};
      out_cfg  <= OUT_CFG_RST;
    end
    else
    begin
      aw_held  <= next_aw_held;
      w_held   <= next_w_held;
      aw_addr  <= next_aw_addr;
      w_data   <= next_w_data;
      w_strb   <= next_w_strb;
      bvalid   <= next_bvalid;
      bresp    <= next_bresp;
      mode     <= next_mode;
      lut_top  <= next_lut_top;
      lut_bot  <= next_lut_bot;
      flop_cfg <= next_flop_cfg;
      out_cfg  <= next_out_cfg;
    end
  end

  // Read path: answer one cycle after the address is taken
  always_comb
  begin
    next_rvalid = rvalid;
    next_rresp  = rresp;
    next_rdata  = rdata;
    if (rvalid && i_s_axi_rready)
      next_rvalid = 1'b0;
    if (i_s_axi_arvalid && o_s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      unique case (i_s_axi_araddr)
        MODE_OFS:     next_rdata = {29'h0, mode};
        LUT_TOP_LO:   next_rdata = lut_top[31:0];
        LUT_TOP_HI:   next_rdata = lut_top[63:32];
        LUT_BOT_LO:   next_rdata = lut_bot[31:0];
        LUT_BOT_HI:   next_rdata = lut_bot[63:32];
        FLOP_TOP_OFS: next_rdata = {22'h0, flop_cfg[0]};
        FLOP_BOT_OFS: next_rdata = {22'h0, flop_cfg[1]};
        OUT_CFG_OFS:  next_rdata = {28'h0, out_cfg};
        STATUS_OFS:   next_rdata = status;
        default:
        begin
          next_rdata = 32'h0;
          next_rresp = RESP_DECERR;
        end
      endcase
    end
  end

  // Read path registers
  always_ff @(posedge i_clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      rvalid <= 1'b0;
      rresp  <= RESP_OKAY;
      rdata  <= 32'h0;
    end
    else
    begin
      rvalid <= next_rvalid;
      rresp  <= next_rresp;
      rdata  <= next_rdata;
    end
  end

  // Datapath: look-up halves, flops and output drivers
  logic       normal_m, ext_m;
  logic [1:0] q, next_q;      // Flop contents
  logic [1:0] q_eff;          // Flop outputs with async clear applied
  logic [1:0] aclr_hit, gate_hit, pack_d, lut_res;
  logic       top_f, bot_f, ext_top5, ext_bot5;
  logic [2:0] cfg_err;

  assign normal_m = (mode == MODE_NORMAL);
  assign ext_m    = (mode == MODE_EXTENDED);

  // Feedback lets a flop drive its own half's f input, packing it with its fan-out
  assign top_f = flop_cfg[0][FC_FB_BIT] ? q_eff[0] : i_lower_sel_f;
  assign bot_f = flop_cfg[1][FC_FB_BIT] ? q_eff[1] : i_upper_sel_f;

  // Extended mode: two five-input halves over a..d, picked by the lower f input
  assign ext_top5 = lut_top[{i_lower_sel_e, i_data_d, i_data_c, i_data_b, i_data_a}];
  assign ext_bot5 = lut_bot[{i_upper_sel_e, i_data_d, i_data_c, i_data_b, i_data_a}];

  // Normal mode: each half is a six-input table; smaller functions are
  // table contents that ignore inputs, so a/b sharing is by construction
  always_comb
  begin
    lut_res = 2'b00;
    if (normal_m)
    begin
      lut_res[0] = lut_top[{top_f, i_lower_sel_e, i_data_d, i_data_c, i_data_b, i_data_a}];
      lut_res[1] = lut_bot[{bot_f, i_upper_sel_e, i_data_d, i_data_c, i_data_b, i_data_a}];
    end
    else if (ext_m)
      lut_res[0] = i_lower_sel_f ? ext_bot5 : ext_top5;
  end

  // Per-flop control; the same loop serves both halves
  for (genvar i = 0; i < 2; i++)
  begin : g_flop
    pack_lane_t lane;
    flop_src_t  src;
    assign lane        = pack_lane_t'(flop_cfg[i][FC_PACK_LSB +: 2]);
    assign src         = flop_src_t'(flop_cfg[i][FC_SRC_LSB +: 2]);
    assign aclr_hit[i] = i_cluster_async_clear[flop_cfg[i][FC_ACLR_BIT]];
    assign gate_hit[i] = (flop_cfg[i][FC_GATE_LSB +: 2] == 2'h3) ? 1'b0
                         : i_cluster_clock_gate[flop_cfg[i][FC_GATE_LSB +: 2]];
    assign q_eff[i]    = q[i] && !aclr_hit[i];

    // Packing lane picks a spare cell input as plain flop data
    always_comb
    begin
      unique case (lane)
        PACK_LOWER_E: pack_d[i] = i_lower_sel_e;
        PACK_LOWER_F: pack_d[i] = i_lower_sel_f;
        PACK_UPPER_F: pack_d[i] = i_upper_sel_f;
        PACK_UPPER_E: pack_d[i] = i_upper_sel_e;
      endcase
    end

    // Priority: async clear, bottom clear in extended mode, then sync clear, sync load, data; only the last three gated by enable
    always_comb
    begin
      next_q[i] = q[i];
      if (aclr_hit[i])
        next_q[i] = 1'b0;
      else if (i == 1 && ext_m)
        next_q[i] = 1'b0;
      else if (gate_hit[i])
      begin
        if (flop_cfg[i][FC_SCLR_BIT] && i_sync_clear)
          next_q[i] = 1'b0;
        else if (flop_cfg[i][FC_SLOAD_BIT] && i_sync_load)
          next_q[i] = i_sync_data[i];
        else
        begin
          unique case (src)
            SRC_LUT:   next_q[i] = lut_res[i];
            SRC_PACK:  next_q[i] = pack_d[i];
            SRC_CHAIN: next_q[i] = (i == 0) ? i_chain_in : q[0];
            SRC_HOLD:  next_q[i] = q[i];
          endcase
        end
      end
    end
  end

  // The two flops of the cell
  always_ff @(posedge i_clk_sys or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      q <= 2'b00;
    else
      q <= next_q;
  end

  // Output drivers: per set, route0 and route1 pick logic result or flop,
  // local follows route0. Bypass is combinational by design.
  assign o_top_route0 = out_cfg[0] ? q_eff[0] : lut_res[0];
  assign o_top_route1 = out_cfg[1] ? q_eff[0] : lut_res[0];
  assign o_top_local  = o_top_route0;
  assign o_bot_route0 = out_cfg[2] ? q_eff[1] : lut_res[1];
  assign o_bot_route1 = out_cfg[3] ? q_eff[1] : lut_res[1];
  assign o_bot_local  = o_bot_route0;
  assign o_chain_out  = q_eff[1];
  // Arithmetic datapaths are not built; chains pass through untouched
  assign o_carry_out  = i_carry_in;
  assign o_share_out  = i_share_in;

  // Configuration checks visible to software
  assign cfg_err[0] = !(normal_m || ext_m);
  assign cfg_err[1] = ext_m && (out_cfg[2] || out_cfg[3]);
  assign cfg_err[2] = ((flop_cfg[0][FC_PACK_LSB +: 2] == 2'h2) || (flop_cfg[1][FC_PACK_LSB +: 2] == 2'h2))
                      && ((normal_m && flop_cfg[1][FC_SRC_LSB +: 2] == 2'h0)
                          || (ext_m && flop_cfg[0][FC_SRC_LSB +: 2] == 2'h0));
  assign status = {24'h0, i_fabric_run, cfg_err, lut_res, q_eff};

  // Checks
  chk_aclr_wins: assert property (@(posedge i_clk_sys) disable iff (!rst_sync_n)
    aclr_hit[0] |=> !q[0]) else $error("top flop not cleared by async clear");
  chk_gate_holds: assert property (@(posedge i_clk_sys) disable iff (!rst_sync_n)
    !gate_hit[0] && !aclr_hit[0] |=> q[0] == $past(q[0])) else $error("top flop moved while gated");
  chk_sclr_first: assert property (@(posedge i_clk_sys) disable iff (!rst_sync_n)
    gate_hit[1] && !aclr_hit[1] && flop_cfg[1][FC_SCLR_BIT] && i_sync_clear |=> !q[1])
    else $error("sync clear ignored");
  chk_sload_data: assert property (@(posedge i_clk_sys) disable iff (!rst_sync_n)
    gate_hit[0] && !aclr_hit[0] && !(flop_cfg[0][FC_SCLR_BIT] && i_sync_clear)
    && flop_cfg[0][FC_SLOAD_BIT] && i_sync_load |=> q[0] == $past(i_sync_data[0]))
    else $error("sync load data not captured");
  chk_lut_capture: assert property (@(posedge i_clk_sys) disable iff (!rst_sync_n)
    gate_hit[0] && !aclr_hit[0] && !i_sync_clear && !i_sync_load && flop_cfg[0][1:0] == 2'h0
    |=> q[0] == $past(lut_res[0])) else $error("top flop missed logic result");
  chk_bypass_comb: assert property (@(posedge i_clk_sys) disable iff (!rst_sync_n)
    !out_cfg[0] |-> o_top_route0 == lut_res[0] && o_top_local == o_top_route0)
    else $error("bypass output wrong");
  chk_both_versions: assert property (@(posedge i_clk_sys) disable iff (!rst_sync_n)
    out_cfg[3:2] == 2'b01 |-> o_bot_route0 == q_eff[1] && o_bot_route1 == lut_res[1])
    else $error("registered and unregistered not both shown");
  chk_ext_bottom: assert property (@(posedge i_clk_sys) disable iff (!rst_sync_n)
    ext_m [*2] |-> !q[1] && !lut_res[1]) else $error("bottom half active in extended mode");
  chk_cfg_static: assert property (@(posedge i_clk_sys) disable iff (!rst_sync_n)
    i_fabric_run && aw_held && w_held |=> bvalid && bresp == RESP_SLVERR && $stable(lut_top) && $stable(mode))
    else $error("configuration changed while running");
  chk_ext_mux: assert property (@(posedge i_clk_sys) disable iff (!rst_sync_n)
    ext_m && i_lower_sel_f |-> lut_res[0] == ext_bot5) else $error("extended mux select wrong");
  cov_write_ok:  cover property (@(posedge i_clk_sys) bvalid && bresp == RESP_OKAY);
  cov_sload:     cover property (@(posedge i_clk_sys) gate_hit[0] && i_sync_load ##1 q[0]);
  cov_extended:  cover property (@(posedge i_clk_sys) ext_m && lut_res[0]);
  cov_feedback:  cover property (@(posedge i_clk_sys) flop_cfg[0][FC_FB_BIT] && q[0] && lut_res[0]);

endmodule

// File: cluster_ctrl_model.sv
// Model of the cluster control block driving the cell's shared controls
`timescale 1ns/100ps
module cluster_ctrl_model
(
  input  wire logic       i_clk,   // System clock
  input  wire logic       i_rst_n, // Reset, active low
  input  wire logic [9:0] i_req,   // Controls requested by routing
  output logic      [9:0] o_ctl    // Registered cluster controls
);
  logic [9:0] next_ctl;

  // Controls reach every flop through one register stage, whatever the mode
  always_comb next_ctl = i_req;

  // Reset parks all gates, clears and loads low
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_ctl <= 10'h000;
    else
      o_ctl <= next_ctl;
  end
endmodule

// File: testbench.sv
// Self-checking bench for the adaptive logic cell
`timescale 1ns/100ps
module testbench;
  import cell_pkg::*;
  logic        clk;
  logic        rst_n;
  logic [9:0]  req;
  logic [9:0]  ctl;
  logic [10:0] din;
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0]  wstrb;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic        t0, t1, tl, b0, b1, bl, chain, carry, share;
  int          failures;
  int          comparisons;

  cluster_ctrl_model u_cluster_ctrl_model (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .o_ctl(ctl));

  adaptive_logic_cell u_adaptive_logic_cell (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_fabric_run(ctl[9]), .i_data_a(din[0]), .i_data_b(din[1]),
    .i_data_c(din[2]), .i_data_d(din[3]), .i_lower_sel_e(din[4]), .i_lower_sel_f(din[5]),
    .i_upper_sel_e(din[6]), .i_upper_sel_f(din[7]), .i_carry_in(din[8]), .i_share_in(din[9]),
    .i_chain_in(din[10]), .i_cluster_clock_gate(ctl[2:0]), .i_cluster_async_clear(ctl[4:3]),
    .i_sync_clear(ctl[5]), .i_sync_load(ctl[6]), .i_sync_data(ctl[8:7]), .o_top_route0(t0),
    .o_top_route1(t1), .o_top_local(tl), .o_bot_route0(b0), .o_bot_route1(b1), .o_bot_local(bl),
    .o_chain_out(chain), .o_carry_out(carry), .o_share_out(share), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb),
    .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready));

  // 40 MHz system clock
  always #12.5 clk = ~clk;

  task automatic check_bit(input logic got, input logic exp);
  begin
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: output %b, expected %b", $time, got, exp);
    end
  end
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
  begin
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: word %h, expected %h", $time, got, exp);
    end
  end
  endtask

  // Readies are sampled before the edge updates land, so each handshake is seen once
  // Open flags are local, since the NBA-driven valids have not landed when the loop tests them
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_open;
    logic w_open;
    logic b_open;
  begin
    @(posedge clk);
    aw_open = 1'b1;
    w_open  = 1'b1;
    b_open  = 1'b1;
    awaddr  <= a;
    wdata   <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    while (aw_open || w_open || b_open)
    begin
      @(posedge clk);
      if (aw_open && awready)
      begin
        aw_open = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_open && wready)
      begin
        w_open = 1'b0;
        wvalid <= 1'b0;
      end
      if (b_open && bvalid)
      begin
        b_open = 1'b0;
        bready <= 1'b0;
        check_word({30'h0, bresp}, {30'h0, er});
      end
    end
  end
  endtask

  // Only the watchdog ends a wait that never gets its answer
  task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_open;
    logic r_open;
  begin
    @(posedge clk);
    ar_open = 1'b1;
    r_open  = 1'b1;
    araddr  <= a;
    {arvalid, rready} <= 2'h3;
    while (ar_open || r_open)
    begin
      @(posedge clk);
      if (ar_open && arready)
      begin
        ar_open = 1'b0;
        arvalid <= 1'b0;
      end
      if (r_open && rvalid)
      begin
        r_open = 1'b0;
        rready <= 1'b0;
        check_word(rdata, ed);
        check_word({30'h0, rresp}, {30'h0, er});
      end
    end
  end
  endtask

  // One edge to the control register, one to the flop, one spare
  task automatic drive(input logic [10:0] d, input logic [9:0] r);
  begin
    @(posedge clk);
    din <= d;
    req <= r;
    repeat (3) @(posedge clk);
    #1;
  end
  endtask

  task automatic close_out();
  begin
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask

  // Tests need well under 1000 cycles; this margin only catches a hang
  initial
  begin
    #(25 * 4000);
    failures++;
    close_out();
  end

  // Main sequence
  initial
  begin
    {clk, rst_n, failures, comparisons} = '0;
    {req, din, awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    wstrb = 4'hf;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    axi_read(MODE_OFS, 32'h0, RESP_OKAY);
    axi_read(OUT_CFG_OFS, 32'h0, RESP_OKAY);
    axi_read(8'h24, 32'h0, RESP_DECERR);
    axi_write(STATUS_OFS, 32'h1, RESP_SLVERR);
    // Top half computes input a while lower f is low; its flop drives route1, route0 stays raw
    axi_write(LUT_TOP_LO, 32'haaaaaaaa, RESP_OKAY);
    axi_write(LUT_TOP_HI, 32'h0, RESP_OKAY);
    axi_write(FLOP_TOP_OFS, 32'h180, RESP_OKAY);
    axi_write(OUT_CFG_OFS, 32'h2, RESP_OKAY);
    drive(11'h001, 10'h001);
    check_bit(t0, 1'b1);
    check_bit(t1, 1'b1);
    check_bit(tl, 1'b1);
    // Gate drops before the data does, so the flop must hold
    drive(11'h001, 10'h000);
    drive(11'h000, 10'h000);
    check_bit(t0, 1'b0);
    check_bit(t1, 1'b1);
    drive(11'h021, 10'h000);
    check_bit(t0, 1'b0);
    // Load, clear over load, then async clear over a live gate
    drive(11'h001, 10'h041);
    check_bit(t1, 1'b0);
    drive(11'h001, 10'h0e1);
    check_bit(t1, 1'b0);
    drive(11'h001, 10'h001);
    check_bit(t1, 1'b1);
    drive(11'h001, 10'h009);
    check_bit(t1, 1'b0);
    // Writes refused while the fabric runs
    drive(11'h100, 10'h200);
    check_bit(carry, 1'b1);
    check_bit(share, 1'b0);
    axi_write(MODE_OFS, 32'h1, RESP_SLVERR);
    drive(11'h000, 10'h000);
    axi_read(MODE_OFS, 32'h0, RESP_OKAY);
    // Bottom half follows upper f; flop on route0, raw result on route1
    axi_write(LUT_BOT_HI, 32'hffffffff, RESP_OKAY);
    axi_write(FLOP_BOT_OFS, 32'h80, RESP_OKAY);
    axi_write(OUT_CFG_OFS, 32'h4, RESP_OKAY);
    drive(11'h080, 10'h001);
    check_bit(b0, 1'b1);
    check_bit(b1, 1'b1);
    check_bit(bl, 1'b1);
    drive(11'h080, 10'h000);
    drive(11'h000, 10'h000);
    check_bit(b0, 1'b1);
    check_bit(b1, 1'b0);
    drive(11'h080, 10'h021);
    check_bit(b0, 1'b0);
    // Extended mode: lower f picks between the two five-input halves
    axi_write(MODE_OFS, 32'h1, RESP_OKAY);
    axi_write(LUT_TOP_LO, 32'hffffffff, RESP_OKAY);
    axi_write(LUT_BOT_LO, 32'h0, RESP_OKAY);
    axi_write(FLOP_BOT_OFS, 32'h2, RESP_OKAY);
    axi_write(OUT_CFG_OFS, 32'h6, RESP_OKAY);
    drive(11'h000, 10'h001);
    check_bit(t0, 1'b1);
    check_bit(t1, 1'b1);
    check_bit(b0, 1'b0);
    check_bit(chain, 1'b0);
    drive(11'h020, 10'h001);
    check_bit(t0, 1'b0);
    axi_read(STATUS_OFS, 32'h20, RESP_OKAY);
    close_out();
  end
endmodule
